// ===== bdms_pkg.sv
`default_nettype none
package bdms_pkg;
    // file addresses, full 8-bit form; shared core registers use the low 7 bits
    localparam logic [7:0] ADDR_INDIRECT_DATA = 8'h00;
    localparam logic [7:0] ADDR_TIMER_COUNT = 8'h01;
    localparam logic [7:0] ADDR_PC_LOW = 8'h02;
    localparam logic [7:0] ADDR_CORE_FLAGS = 8'h03;
    localparam logic [7:0] ADDR_INDIRECT_POINTER = 8'h04;
    localparam logic [7:0] ADDR_PORT_A_PINS = 8'h05;
    localparam logic [7:0] ADDR_PORT_B_PINS = 8'h06;
    localparam logic [7:0] ADDR_PC_HIGH_LATCH = 8'h0A;
    localparam logic [7:0] ADDR_INTERRUPT_CONTROL = 8'h0B;
    localparam logic [7:0] ADDR_PERIPH_IRQ_FLAGS = 8'h0C;
    localparam logic [7:0] ADDR_COMPARATOR_CONTROL = 8'h1F;
    localparam logic [7:0] ADDR_PRESCALER_OPTIONS = 8'h81;
    localparam logic [7:0] ADDR_PORT_A_DIRECTION = 8'h85;
    localparam logic [7:0] ADDR_PORT_B_DIRECTION = 8'h86;
    localparam logic [7:0] ADDR_PERIPH_IRQ_ENABLES = 8'h8C;
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h8E;
    localparam logic [7:0] ADDR_VREF_CONTROL = 8'h9F;
    // general purpose ranges and their word index bases
    localparam logic [7:0] GPR_BANK0_LO = 8'h20;
    localparam logic [7:0] GPR_BANK0_HI = 8'h7F;
    localparam logic [7:0] GPR_BANK1_LO = 8'hA0;
    localparam logic [7:0] GPR_BANK1_HI = 8'hBF;
    localparam logic [7:0] GPR_MIRROR_LO = 8'hF0;
    localparam logic [7:0] GPR_BANK0_BASE = 8'h20;
    localparam logic [7:0] GPR_BANK1_BASE = 8'h40;
    localparam logic [7:0] GPR_MIRROR_BASE = 8'hA0;
    localparam int GPR_DEPTH = 128;
    // core_flags field positions
    localparam int STAT_CARRY = 0;
    localparam int STAT_DIGIT_CARRY = 1;
    localparam int STAT_ZERO = 2;
    localparam int STAT_POWER_DOWN = 3;
    localparam int STAT_TIMEOUT = 4;
    localparam int STAT_BANK_LOW = 5;
    localparam logic [7:0] STATUS_RESET = 8'h18;
    localparam logic [7:0] POINTER_RESET = 8'h00;
    localparam logic [7:0] PC_HIGH_RESET = 8'h00;

    typedef enum logic [3:0] {
        OP_MOVE_FROM_W_INSTR, OP_CLEAR_FILE_INSTR, OP_MOVF, OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR,
        OP_SWAP, OP_BCF, OP_BSF
    } bdms_op_t;

    typedef enum logic [2:0] {
        CLS_NONE, CLS_INDIRECT, CLS_STATUS, CLS_POINTER, CLS_PC_HIGH, CLS_GPR, CLS_EXT
    } bdms_cls_t;

    // which flags an operation drives: {zero, digit carry, carry}
    function automatic logic [2:0] bdms_flag_mask(input bdms_op_t op);
        case (op)
            OP_ADD, OP_SUB: bdms_flag_mask = 3'h7;
            OP_CLEAR_FILE_INSTR, OP_MOVF, OP_AND, OP_IOR, OP_XOR: bdms_flag_mask = 3'h4;
            default: bdms_flag_mask = 3'h0;
        endcase
    endfunction : bdms_flag_mask
endpackage : bdms_pkg
`default_nettype wire

// ===== bdms_gpr_mem.sv
`timescale 1ns/100ps
`default_nettype none
module bdms_gpr_mem #(
    parameter int DEPTH = bdms_pkg::GPR_DEPTH,
    parameter int AW = 7,
    parameter int DW = 8
) (
    input wire logic ref_clk,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output var logic [DW-1:0] rd_data,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge ref_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rd_en)
        begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : bdms_gpr_mem
`default_nettype wire

// ===== bdms_alu.sv
`timescale 1ns/100ps
`default_nettype none
module bdms_alu (
    input wire bdms_pkg::bdms_op_t op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic [2:0] bit_sel,
    output logic [7:0] result,
    output logic z,
    output logic dc,
    output logic c
);
    import bdms_pkg::*;
    logic [8:0] sum9;
    logic [4:0] nib5;

    always_comb
    begin
        sum9 = 9'h000;
        nib5 = 5'h00;
        result = a;
        dc = 1'b0;
        c = 1'b0;
        case (op)
            OP_MOVE_FROM_W_INSTR: result = b;
            OP_CLEAR_FILE_INSTR: result = 8'h00;
            OP_ADD:
            begin
                sum9 = {1'b0, a} + {1'b0, b};
                nib5 = {1'b0, a[3:0]} + {1'b0, b[3:0]};
                result = sum9[7:0];
                c = sum9[8];
                dc = nib5[4];
            end
            OP_SUB:
            begin
                // carries read as inverted borrows
                sum9 = {1'b0, a} - {1'b0, b};
                nib5 = {1'b0, a[3:0]} - {1'b0, b[3:0]};
                result = sum9[7:0];
                c = ~sum9[8];
                dc = ~nib5[4];
            end
            OP_AND: result = a & b;
            OP_IOR: result = a | b;
            OP_XOR: result = a ^ b;
            OP_SWAP: result = {a[3:0], a[7:4]};
            OP_BCF: result = a & ~(8'h01 << bit_sel);
            OP_BSF: result = a | (8'h01 << bit_sel);
            default: result = a;
        endcase
        z = (result == 8'h00);
    end
endmodule : bdms_alu
`default_nettype wire

// ===== bdms_core_regs.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - status holds flags, reset cause, bank bits
// - status writable as a file register, reset-cause bits excepted
// - flag-updating ops override data to flags
// - timeout and power-down ignore instruction writes
// - clear on status: upper zero, zero set
// - bit, swap, move-from-W ops store all writable bits
// - subtract carries are inverted borrows
// - master clear low holds block in reset
module bdms_core_regs (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic master_clear_n,
    input wire logic instr_valid,
    input wire bdms_pkg::bdms_op_t instr_op,
    input wire logic [6:0] instr_addr,
    input wire logic [7:0] instr_w,
    input wire logic [7:0] instr_lit,
    input wire logic instr_use_lit,
    input wire logic [2:0] instr_bit,
    input wire logic instr_to_file,
    input wire logic wdt_timeout,
    input wire logic sleep_entry,
    input wire logic wdt_clear,
    input wire logic [7:0] ext_rd_data,
    output logic ready_ff,
    output logic done_ff,
    output logic [7:0] result_ff,
    output logic [7:0] status_ff,
    output logic [7:0] ext_addr_ff,
    output logic ext_wr_ff,
    output logic [7:0] ext_wdata_ff,
    output logic core_reset_ff
);
    import bdms_pkg::*;

    typedef enum {ST_IDLE, ST_EXEC} bdms_state_t;

    bdms_state_t state_ff;
    logic master_clear_n_meta_ff;
    logic master_clear_n_sync_ff;
    logic core_rst;
    logic take;
    logic [7:0] ptr_ff;
    logic [7:0] pc_high_ff;
    bdms_op_t op_ff;
    bdms_cls_t cls_ff;
    bdms_cls_t nxt_cls;
    logic [7:0] w_ff;
    logic [7:0] lit_ff;
    logic use_lit_ff;
    logic [2:0] bit_ff;
    logic to_file_ff;
    logic [7:0] eff_addr;
    logic [6:0] gpr_rd_addr;
    logic [6:0] gpr_wr_addr_ff;
    logic [7:0] gpr_rd_data;
    logic gpr_wr;
    logic [7:0] operand;
    logic [7:0] alu_res;
    logic alu_z;
    logic alu_dc;
    logic alu_c;
    logic [2:0] flag_mask;
    logic [7:0] nxt_status;
    logic status_event;

    // address class of an effective file address
    function automatic bdms_cls_t bdms_decode(input logic [7:0] a);
        logic [6:0] low;
        low = a[6:0];
        if (low == ADDR_INDIRECT_DATA[6:0])
            bdms_decode = CLS_INDIRECT;
        else if (low == ADDR_CORE_FLAGS[6:0])
            bdms_decode = CLS_STATUS;
        else if (low == ADDR_INDIRECT_POINTER[6:0])
            bdms_decode = CLS_POINTER;
        else if (low == ADDR_PC_HIGH_LATCH[6:0])
            bdms_decode = CLS_PC_HIGH;
        else if (low == ADDR_PC_LOW[6:0] || low == ADDR_INTERRUPT_CONTROL[6:0])
            bdms_decode = CLS_EXT;
        else if (a == ADDR_TIMER_COUNT || a == ADDR_PORT_A_PINS || a == ADDR_PORT_B_PINS
                 || a == ADDR_PERIPH_IRQ_FLAGS || a == ADDR_COMPARATOR_CONTROL
                 || a == ADDR_PRESCALER_OPTIONS || a == ADDR_PORT_A_DIRECTION
                 || a == ADDR_PORT_B_DIRECTION || a == ADDR_PERIPH_IRQ_ENABLES
                 || a == ADDR_POWER_CONTROL || a == ADDR_VREF_CONTROL)
            bdms_decode = CLS_EXT;
        else if ((a >= GPR_BANK0_LO && a <= GPR_BANK0_HI)
                 || (a >= GPR_BANK1_LO && a <= GPR_BANK1_HI) || a >= GPR_MIRROR_LO)
            bdms_decode = CLS_GPR;
        else
            bdms_decode = CLS_NONE;
    endfunction : bdms_decode

    // word index; top of bank 1 folds onto top of bank 0
    function automatic logic [6:0] bdms_gpr_index(input logic [7:0] a);
        logic [7:0] idx;
        if (a >= GPR_MIRROR_LO)
            idx = a - GPR_MIRROR_BASE;
        else if (a >= GPR_BANK1_LO)
            idx = a - GPR_BANK1_BASE;
        else
            idx = a - GPR_BANK0_BASE;
        bdms_gpr_index = idx[6:0];
    endfunction : bdms_gpr_index

    // master clear pin synchroniser
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            master_clear_n_meta_ff <= 1'b0;
            master_clear_n_sync_ff <= 1'b0;
        end
        else
        begin
            master_clear_n_meta_ff <= master_clear_n;
            master_clear_n_sync_ff <= master_clear_n_meta_ff;
        end
    end

    assign core_rst = rst | ~master_clear_n_sync_ff;

    always_ff @(posedge ref_clk)
    begin
        core_reset_ff <= core_rst;
    end

    assign take = instr_valid && state_ff == ST_IDLE;

    // direct access banked by status, indirect access by pointer
    always_comb
    begin
        eff_addr = {status_ff[STAT_BANK_LOW], instr_addr};
        nxt_cls = bdms_decode(eff_addr);
        if (nxt_cls == CLS_INDIRECT)
        begin
            eff_addr = ptr_ff;
            nxt_cls = bdms_decode(eff_addr);
            if (nxt_cls == CLS_INDIRECT)
                nxt_cls = CLS_NONE;
        end
        gpr_rd_addr = bdms_gpr_index(eff_addr);
    end

    always_ff @(posedge ref_clk)
    begin
        if (core_rst)
            state_ff <= ST_IDLE;
        else
        begin
            case (state_ff)
                ST_IDLE:
                    if (instr_valid)
                        state_ff <= ST_EXEC;
                ST_EXEC:
                    state_ff <= ST_IDLE;
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (core_rst)
        begin
            ready_ff <= 1'b1;
            done_ff <= 1'b0;
        end
        else
        begin
            ready_ff <= !take;
            done_ff <= state_ff == ST_EXEC;
        end
    end

    // instruction capture
    always_ff @(posedge ref_clk)
    begin
        if (core_rst)
        begin
            op_ff <= OP_MOVF;
            cls_ff <= CLS_NONE;
            w_ff <= 8'h00;
            lit_ff <= 8'h00;
            use_lit_ff <= 1'b0;
            bit_ff <= 3'h0;
            to_file_ff <= 1'b0;
            ext_addr_ff <= 8'h00;
            gpr_wr_addr_ff <= 7'h00;
        end
        else if (take)
        begin
            op_ff <= instr_op;
            cls_ff <= instr_use_lit ? CLS_NONE : nxt_cls;
            w_ff <= instr_w;
            lit_ff <= instr_lit;
            use_lit_ff <= instr_use_lit;
            bit_ff <= instr_bit;
            to_file_ff <= instr_to_file && !instr_use_lit;
            ext_addr_ff <= eff_addr;
            gpr_wr_addr_ff <= gpr_rd_addr;
        end
    end

    bdms_gpr_mem #(
        .DEPTH(GPR_DEPTH),
        .AW(7),
        .DW(8)
    ) u_gpr (
        .ref_clk(ref_clk),
        .rd_en(take),
        .rd_addr(gpr_rd_addr),
        .rd_data(gpr_rd_data),
        .wr_en(gpr_wr),
        .wr_addr(gpr_wr_addr_ff),
        .wr_data(alu_res)
    );

    // source operand by class; unbacked locations read zero
    always_comb
    begin
        case (cls_ff)
            CLS_STATUS: operand = status_ff;
            CLS_POINTER: operand = ptr_ff;
            CLS_PC_HIGH: operand = pc_high_ff;
            CLS_GPR: operand = gpr_rd_data;
            CLS_EXT: operand = ext_rd_data;
            default: operand = 8'h00;
        endcase
        if (use_lit_ff)
            operand = lit_ff;
    end

    bdms_alu u_alu (
        .op(op_ff),
        .a(operand),
        .b(w_ff),
        .bit_sel(bit_ff),
        .result(alu_res),
        .z(alu_z),
        .dc(alu_dc),
        .c(alu_c)
    );

    assign flag_mask = bdms_flag_mask(op_ff);
    assign gpr_wr = state_ff == ST_EXEC && to_file_ff && cls_ff == CLS_GPR;
    assign status_event = wdt_timeout | sleep_entry | wdt_clear;

    always_comb
    begin
        nxt_status = status_ff;
        if (state_ff == ST_EXEC)
        begin
            if (to_file_ff && cls_ff == CLS_STATUS)
            begin
                nxt_status[7:5] = alu_res[7:5];
                if (flag_mask == 3'h0)
                    nxt_status[2:0] = alu_res[2:0];
            end
            // flag results win over the written data
            if (flag_mask[2])
                nxt_status[STAT_ZERO] = alu_z;
            if (flag_mask[1])
                nxt_status[STAT_DIGIT_CARRY] = alu_dc;
            if (flag_mask[0])
                nxt_status[STAT_CARRY] = alu_c;
        end
        // reset-cause bits move only on core events
        if (wdt_clear)
        begin
            nxt_status[STAT_TIMEOUT] = 1'b1;
            nxt_status[STAT_POWER_DOWN] = 1'b1;
        end
        else
        begin
            if (wdt_timeout)
                nxt_status[STAT_TIMEOUT] = 1'b0;
            if (sleep_entry)
                nxt_status[STAT_POWER_DOWN] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (core_rst)
            status_ff <= STATUS_RESET;
        else
            status_ff <= nxt_status;
    end

    always_ff @(posedge ref_clk)
    begin
        if (core_rst)
        begin
            ptr_ff <= POINTER_RESET;
            pc_high_ff <= PC_HIGH_RESET;
        end
        else if (state_ff == ST_EXEC && to_file_ff)
        begin
            if (cls_ff == CLS_POINTER)
                ptr_ff <= alu_res;
            if (cls_ff == CLS_PC_HIGH)
                pc_high_ff <= alu_res;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (core_rst)
        begin
            result_ff <= 8'h00;
            ext_wr_ff <= 1'b0;
            ext_wdata_ff <= 8'h00;
        end
        else
        begin
            ext_wr_ff <= state_ff == ST_EXEC && to_file_ff && cls_ff == CLS_EXT;
            if (state_ff == ST_EXEC)
            begin
                result_ff <= alu_res;
                ext_wdata_ff <= alu_res;
            end
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    logic fin_status;
    assign fin_status = done_ff && to_file_ff && cls_ff == CLS_STATUS;

    property p_reset_value;
        core_reset_ff |-> status_ff == STATUS_RESET && ready_ff;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("status not at reset value");

    property p_pointer_write;
        done_ff && to_file_ff && cls_ff == CLS_POINTER |-> ptr_ff == result_ff;
    endproperty
    a_pointer_write: assert property (p_pointer_write) else $error("pointer not written");

    property p_flag_override;
        fin_status && bdms_flag_mask(op_ff) != 3'h0 && !$past(core_rst)
            |-> status_ff[STAT_ZERO] == (result_ff == 8'h00);
    endproperty
    a_flag_override: assert property (p_flag_override) else $error("zero flag took data");

    property p_reset_cause_kept;
        fin_status && !$past(status_event) && !$past(core_rst)
            |-> status_ff[4:3] == $past(status_ff[4:3]);
    endproperty
    a_reset_cause_kept: assert property (p_reset_cause_kept) else $error("reset cause written");

    property p_clear_status;
        fin_status && op_ff == OP_CLEAR_FILE_INSTR && !$past(core_rst)
            |-> status_ff[7:5] == 3'h0 && status_ff[STAT_ZERO]
                && status_ff[1:0] == $past(status_ff[1:0]);
    endproperty
    a_clear_status: assert property (p_clear_status) else $error("clear on status wrong");

    property p_neutral_store;
        fin_status && op_ff inside {OP_BCF, OP_BSF, OP_SWAP, OP_MOVE_FROM_W_INSTR} && !$past(core_rst)
            |-> status_ff[7:5] == result_ff[7:5] && status_ff[2:0] == result_ff[2:0];
    endproperty
    a_neutral_store: assert property (p_neutral_store) else $error("status store lost");

    property p_sub_borrow;
        done_ff && op_ff == OP_SUB && !$past(core_rst)
            |-> status_ff[STAT_CARRY] == ($past(operand) >= $past(w_ff))
                && status_ff[STAT_DIGIT_CARRY] == ($past(operand[3:0]) >= $past(w_ff[3:0]));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("borrow polarity wrong");

    property p_master_clear;
        !master_clear_n [*3] |=> core_reset_ff && ready_ff && !done_ff;
    endproperty
    a_master_clear: assert property (p_master_clear) else $error("master clear ignored");

    property p_shared_status;
        take && !instr_use_lit && instr_addr == ADDR_CORE_FLAGS[6:0] |=> cls_ff == CLS_STATUS;
    endproperty
    a_shared_status: assert property (p_shared_status) else $error("status not shared");

    property p_unmapped_zero;
        done_ff && cls_ff == CLS_NONE && !use_lit_ff && op_ff == OP_MOVF |-> result_ff == 8'h00;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    c_status_clear: cover property (fin_status && op_ff == OP_CLEAR_FILE_INSTR);
    c_sub_status: cover property (fin_status && op_ff == OP_SUB);
    c_bank1_gpr: cover property (take && status_ff[STAT_BANK_LOW] && nxt_cls == CLS_GPR);
    c_indirect: cover property (take && instr_addr == 7'h00 && !instr_use_lit);
endmodule : bdms_core_regs
`default_nettype wire

// ===== bdms_periph_model.sv
`timescale 1ns/100ps
`default_nettype none
module bdms_periph_model (
    input wire logic ref_clk,
    input wire logic [7:0] ext_addr,
    input wire logic ext_wr,
    input wire logic [7:0] ext_wdata,
    output logic [7:0] ext_rd_data
);
    logic [7:0] regs [256];
    // known start pattern so the bench can predict reads
    initial
    begin
        for (int i = 0; i < 256; i++)
            regs[i] = 8'(i) ^ 8'h5A;
    end
    assign ext_rd_data = regs[ext_addr];
    always @(posedge ref_clk)
    begin
        if (ext_wr)
            regs[ext_addr] <= ext_wdata;
    end
endmodule : bdms_periph_model
`default_nettype wire

// ===== tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import bdms_pkg::*;
    logic ref_clk = 0;
    logic rst = 1;
    logic master_clear_n = 1;
    logic instr_valid = 0;
    bdms_op_t instr_op = OP_MOVE_FROM_W_INSTR;
    logic [6:0] instr_addr = '0;
    logic [7:0] instr_w = '0;
    logic [7:0] instr_lit = '0;
    logic instr_use_lit = 0;
    logic [2:0] instr_bit = '0;
    logic instr_to_file = 0;
    logic wdt_timeout = 0;
    logic sleep_entry = 0;
    logic wdt_clear = 0;
    logic [7:0] ext_rd_data;
    logic ready_ff, done_ff, ext_wr_ff, core_reset_ff;
    logic [7:0] result_ff, status_ff, ext_addr_ff, ext_wdata_ff;
    logic [7:0] mem [256];
    logic [7:0] peri [256];
    logic [7:0] st, ptr, pch;
    logic [6:0] tbl [12] = '{7'h07, 7'h05, 7'h06, 7'h0C, 7'h01, 7'h1F, 7'h0D, 7'h0E, 7'h0A,
        7'h45, 7'h33, 7'h7C};
    logic [7:0] tl [6] = '{8'h05, 8'h04, 8'h10, 8'h1F, 8'h00, 8'hFF};
    logic [7:0] tw [6] = '{8'h05, 8'h05, 8'h01, 8'h0F, 8'h80, 8'h01};
    int errors = 0;
    int num_checks = 0;
    int cyc = 0;

    bdms_core_regs dut_u (.ref_clk, .rst, .master_clear_n, .instr_valid, .instr_op, .instr_addr,
        .instr_w, .instr_lit, .instr_use_lit, .instr_bit, .instr_to_file, .wdt_timeout,
        .sleep_entry, .wdt_clear, .ext_rd_data, .ready_ff, .done_ff, .result_ff, .status_ff,
        .ext_addr_ff, .ext_wr_ff, .ext_wdata_ff, .core_reset_ff);
    bdms_periph_model pm_u (.ref_clk(ref_clk), .ext_addr(ext_addr_ff), .ext_wr(ext_wr_ff),
        .ext_wdata(ext_wdata_ff), .ext_rd_data(ext_rd_data));

    always #4 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("errors=%0d checks=%0d", errors, num_checks);
        if (errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit

    // 1 status, 2 pointer, 3 pc high, 4 memory, 5 peripheral, 0 unimplemented
    function automatic int kind(input logic [7:0] a);
        if (a[6:0] == 7'h03) return 1;
        if (a[6:0] == 7'h04) return 2;
        if (a[6:0] == 7'h0A) return 3;
        if (a[6:0] == 7'h02 || a[6:0] == 7'h0B) return 5;
        if ((a >= 8'h20 && a <= 8'h7F) || (a >= 8'hA0 && a <= 8'hBF) || a >= 8'hF0) return 4;
        if (a inside {8'h01, 8'h05, 8'h06, 8'h0C, 8'h1F, 8'h81, 8'h85, 8'h86, 8'h8C, 8'h8E,
            8'h9F}) return 5;
        return 0;
    endfunction : kind

    function automatic logic [7:0] gk(input logic [7:0] a);
        return (a >= 8'hF0) ? a - 8'h80 : a;
    endfunction : gk

    task automatic exec(input bdms_op_t op, input logic [6:0] ad, input logic [7:0] w,
        input logic [7:0] lit, input logic ul, input logic [2:0] bn, input logic tf,
        input bit rf = 0);
        logic [7:0] e, a, r;
        logic [8:0] s;
        logic [2:0] f, m;
        logic sw, ew;
        int k, n;
        e = (ad == 7'h00) ? ptr : {st[5], ad};
        k = kind(e);
        case (k)
            1: a = st;
            2: a = ptr;
            3: a = pch;
            4: a = mem[gk(e)];
            5: a = peri[e];
            default: a = 8'h00;
        endcase
        if (ul)
            a = lit;
        s = {1'b0, a} + {1'b0, w};
        f = {1'b0, ({1'b0, a[3:0]} + {1'b0, w[3:0]}) > 5'h0F, s[8]};
        m = 3'h4;
        case (op)
            OP_MOVE_FROM_W_INSTR: r = w;
            OP_CLEAR_FILE_INSTR: r = 8'h00;
            OP_MOVF: r = a;
            OP_ADD: r = s[7:0];
            OP_SUB: r = a - w;
            OP_AND: r = a & w;
            OP_IOR: r = a | w;
            OP_XOR: r = a ^ w;
            OP_SWAP: r = {a[3:0], a[7:4]};
            OP_BCF: r = a & ~(8'h01 << bn);
            default: r = a | (8'h01 << bn);
        endcase
        if (op inside {OP_ADD, OP_SUB}) m = 3'h7;
        if (op inside {OP_MOVE_FROM_W_INSTR, OP_SWAP, OP_BCF, OP_BSF}) m = 3'h0;
        if (op == OP_SUB) f[1:0] = {a[3:0] >= w[3:0], a >= w};
        f[2] = (r == 8'h00);
        sw = tf && !ul && k == 1;
        ew = 0;
        for (int i = 0; i < 3; i++)
            if (m[i]) st[i] = f[i];
            else if (sw && m == 3'h0) st[i] = r[i];
        if (tf && !ul)
            case (k)
                1: st[7:5] = r[7:5];
                2: ptr = r;
                3: pch = r;
                4: mem[gk(e)] = r;
                5: begin peri[e] = r; ew = 1; end
                default: ;
            endcase
        @(posedge ref_clk);
        instr_valid <= 1;
        instr_op <= op;
        instr_addr <= ad;
        instr_w <= w;
        instr_lit <= lit;
        instr_use_lit <= ul;
        instr_bit <= bn;
        instr_to_file <= tf;
        @(posedge ref_clk);
        // a request held while busy must be dropped
        if (rf) begin instr_op <= OP_MOVE_FROM_W_INSTR; instr_addr <= 7'h21; instr_w <= 8'hEE; end
        else instr_valid <= 0;
        @(posedge ref_clk);
        instr_valid <= 0;
        n = 0;
        #1;
        while (done_ff !== 1'b1 && n < 4)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk_bit(done_ff, 1'b1);
        chk_bit(ready_ff, 1'b1);
        chk_byte(result_ff, r);
        chk_byte(status_ff, st);
        chk_bit(ext_wr_ff, ew);
        if (ew) chk_byte(ext_wdata_ff, r);
        if (!ul) chk_byte(ext_addr_ff, e);
    endtask : exec

    task automatic ev(input logic t, input logic sl, input logic c);
        @(posedge ref_clk);
        wdt_timeout <= t;
        sleep_entry <= sl;
        wdt_clear <= c;
        @(posedge ref_clk);
        {wdt_timeout, sleep_entry, wdt_clear} <= 3'b000;
        repeat (3) @(posedge ref_clk);
        #1;
        if (c) st[4:3] = 2'b11;
        else begin if (t) st[4] = 0; if (sl) st[3] = 0; end
        chk_byte(status_ff, st);
    endtask : ev

    initial
    begin
        int n;
        void'($urandom(32'hd329));
        for (int i = 0; i < 256; i++) peri[i] = 8'(i) ^ 8'h5A;
        st = 8'h18;
        ptr = 8'h00;
        pch = 8'h00;
        repeat (3) @(posedge ref_clk);
        rst <= 0;
        n = 0;
        while (core_reset_ff !== 1'b0 && n < 10) begin @(posedge ref_clk); n++; end
        @(posedge ref_clk);
        #1;
        chk_byte(status_ff, st);
        for (int i = 8'h20; i <= 8'h7F; i++) exec(OP_MOVE_FROM_W_INSTR, 7'(i), 8'($urandom), 0, 0, 0, 1);
        exec(OP_BSF, 7'h03, 0, 0, 0, 3'd5, 1);
        for (int i = 8'h20; i <= 8'h3F; i++) exec(OP_MOVE_FROM_W_INSTR, 7'(i), 8'($urandom), 0, 0, 0, 1);
        exec(OP_MOVE_FROM_W_INSTR, 7'h03, 8'h07, 0, 0, 0, 1);
        exec(OP_MOVE_FROM_W_INSTR, 7'h03, 8'h27, 0, 0, 0, 1);
        exec(OP_ADD, 7'h03, 8'hE1, 0, 0, 0, 1);
        exec(OP_CLEAR_FILE_INSTR, 7'h03, 0, 0, 0, 0, 1);
        for (int j = 0; j < 6; j++) exec(OP_SUB, 7'h20, tw[j], tl[j], 1, 0, 0);
        for (int j = 0; j < 6; j++) exec(OP_ADD, 7'h20, tw[j], tl[j], 1, 0, 0);
        for (int o = 0; o < 11; o++)
            exec(bdms_op_t'(o), 7'h30 + 7'(o), 8'($urandom), 8'($urandom), 0, 3'(o), 1);
        exec(OP_MOVE_FROM_W_INSTR, 7'h04, 8'hF3, 0, 0, 0, 1);
        exec(OP_MOVF, 7'h00, 0, 0, 0, 0, 0);
        exec(OP_MOVE_FROM_W_INSTR, 7'h00, 8'h9C, 0, 0, 0, 1);
        exec(OP_MOVF, 7'h73, 0, 0, 0, 0, 0);
        exec(OP_MOVE_FROM_W_INSTR, 7'h04, 8'h80, 0, 0, 0, 1);
        exec(OP_MOVE_FROM_W_INSTR, 7'h00, 8'h55, 0, 0, 0, 1);
        exec(OP_MOVF, 7'h00, 0, 0, 0, 0, 0);
        exec(OP_MOVE_FROM_W_INSTR, 7'h07, 8'hAA, 0, 0, 0, 1);
        exec(OP_MOVF, 7'h07, 0, 0, 0, 0, 0);
        exec(OP_MOVE_FROM_W_INSTR, 7'h22, 8'h11, 0, 0, 0, 1, 1);
        exec(OP_MOVF, 7'h21, 0, 0, 0, 0, 0);
        for (int b = 0; b < 2; b++)
        begin
            exec(b ? OP_BSF : OP_BCF, 7'h03, 0, 0, 0, 3'd5, 1);
            repeat (80)
                exec(bdms_op_t'($urandom % 11),
                    ($urandom % 2) ? 7'(32'h20 + $urandom % 96) : tbl[$urandom % 12],
                    8'($urandom), 8'($urandom), ($urandom % 4) == 0, 3'($urandom),
                    1'($urandom));
        end
        ev(0, 1, 0);
        ev(1, 0, 0);
        ev(1, 1, 1);
        @(posedge ref_clk);
        master_clear_n <= 0;
        repeat (4) @(posedge ref_clk);
        #1;
        chk_bit(core_reset_ff, 1'b1);
        chk_bit(done_ff, 1'b0);
        master_clear_n <= 1;
        repeat (6) @(posedge ref_clk);
        #1;
        chk_bit(core_reset_ff, 1'b0);
        summarize();
    end
endmodule : tb
`default_nettype wire
